// ==== hw/sc_type_b_map.vh ====
// How it works
// - Control register zero bit 7 picks 16 or 32 feedback capacitor units.
// - Phase-swap set makes internal phase one follow external phase two, and back.
// - With phase-swap and sample-hold disable clear, an enabled output joins the output bus only during the last half of phase two.
// - Phase-swap set connects the output bus for the whole of phase two.
// - Global sample-hold disable connects every enabled output for all of phase two.
// - Comparator latch captures on one phase's fall, presents on the other's rise.
// - Comparator bus value holds steady between consecutive output events.
// - Swap clear: capture falling phase two, output rising phase one; set: reversed.
// - Control zero bit 5 swaps which internal phase samples input and reference.
// - Control zero bits 4..0 give the A-path capacitor as 0 to 31 units.
// - Control one bits 7..5 select A input; 100 is high reference; 110, 111 reserved.
// - Control one bits 4..0 give the B-path capacitor as 0 to 31 units.
// - Each block has control zero and one at fixed offsets, same in both banks.
// - Phase-swap also shapes the analog column bus drive with the column-bus enable.
// - Column-bus enable clear tri-states the bus; set lets phase-swap choose gating.
// - A comparator column bus with no driver is pulled low.
`ifndef SC_TYPE_B_MAP_VH
`define SC_TYPE_B_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define BLK_B11_CTRL0_IDX 8'h84
`define BLK_B11_CTRL1_IDX 8'h85
`define BLK_B13_CTRL0_IDX 8'h8c
`define BLK_B13_CTRL1_IDX 8'h8d
`define BLK_B20_CTRL0_IDX 8'h90
`define BLK_B20_CTRL1_IDX 8'h91
`define BLK_B22_CTRL0_IDX 8'h98
`define BLK_B22_CTRL1_IDX 8'h99
`define BLK_AUX_CTRL_IDX  8'h60
`define BLK_STATUS_IDX    8'h61

// Control register zero fields.
`define CTRL0_FEEDBACK_CAP_SIZE_BIT    7
`define CTRL0_SWAP_BIT    6
`define CTRL0_APLATE_BIT  5
`define CTRL0_A_PATH_CAP_UNITS_MSB    4
`define CTRL0_A_PATH_CAP_UNITS_LSB    0

// Control register one fields.
`define CTRL1_A_INPUT_SELECT_MSB    7
`define CTRL1_A_INPUT_SELECT_LSB    5
`define CTRL1_B_PATH_CAP_UNITS_MSB    4
`define CTRL1_B_PATH_CAP_UNITS_LSB    0

// Auxiliary control fields.
`define AUX_COLBUS_LSB    0
`define AUX_OUTBUS_LSB    4
`define AUX_CMPBUS_LSB    8
`define AUX_SAMPLE_HOLD_DISABLE_BIT     12
`define AUX_WIDTH         13

// Reset values.
`define CTRL_RESET        8'h00
`define AUX_RESET         13'h0000

// Encodings.
`define FEEDBACK_CAP_SIZE_UNITS_SMALL  6'h10
`define FEEDBACK_CAP_SIZE_UNITS_LARGE  6'h20
`define A_INPUT_SELECT_HIGH_REF     3'h4
`define A_INPUT_SELECT_RSVD_A       3'h6
`define A_INPUT_SELECT_RSVD_B       3'h7

// AXI responses.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ==== hw/sc_type_b_control_regs.v ====
`timescale 1ns/10ps
`include "sc_type_b_map.vh"

module sc_type_b_control_regs #(
  parameter NUM_BLK = 4
) (
  input  wire                 i_core_clk,
  input  wire                 i_sys_rst,
  // AXI4-Lite write address channel.
  input  wire [11:0]          i_awaddr,
  input  wire                 i_awvalid,
  output wire                 o_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0]          i_wdata,
  input  wire [3:0]           i_wstrb,
  input  wire                 i_wvalid,
  output wire                 o_wready,
  // AXI4-Lite write response channel.
  output wire [1:0]           o_bresp,
  output wire                 o_bvalid,
  input  wire                 i_bready,
  // AXI4-Lite read channels.
  input  wire [11:0]          i_araddr,
  input  wire                 i_arvalid,
  output wire                 o_arready,
  output wire [31:0]          o_rdata,
  output wire [1:0]           o_rresp,
  output wire                 o_rvalid,
  input  wire                 i_rready,
  // External two-phase clocks and their late-half marker.
  input  wire                 i_ext_phase_one,
  input  wire                 i_ext_phase_two,
  input  wire                 i_phase_two_late_half,
  // Raw comparator outputs, one per block.
  input  wire [NUM_BLK-1:0]   i_comp_out,
  // Analog switch controls, packed per block.
  output wire [6*NUM_BLK-1:0] o_feedback_cap_units,
  output wire [5*NUM_BLK-1:0] o_a_path_cap_units,
  output wire [5*NUM_BLK-1:0] o_b_path_cap_units,
  output wire [3*NUM_BLK-1:0] o_a_input_select,
  output wire [NUM_BLK-1:0]   o_a_input_reserved,
  output wire [NUM_BLK-1:0]   o_a_input_high_reference,
  output wire [NUM_BLK-1:0]   o_int_phase_one,
  output wire [NUM_BLK-1:0]   o_int_phase_two,
  output wire [NUM_BLK-1:0]   o_a_sample_input,
  output wire [NUM_BLK-1:0]   o_a_sample_reference,
  output wire [NUM_BLK-1:0]   o_out_bus_connect,
  output wire [NUM_BLK-1:0]   o_column_bus_gate,
  output wire [NUM_BLK-1:0]   o_column_bus_oe,
  output wire [NUM_BLK-1:0]   o_comparator_column_bus
);

  localparam SEL_NONE = 4'hf;
  localparam SEL_AUX  = 4'h8;
  localparam SEL_STAT = 4'h9;

  // Maps a byte address to a register select: 0..3 control zero, 4..7 control one.
  function [3:0] reg_select;
    input [11:0] addr;
    reg   [9:0]  idx;
    begin
      idx = addr[11:2];
      if (addr[1:0] != 2'h0) begin
        reg_select = SEL_NONE;
      end else if (idx == {2'h0, `BLK_B11_CTRL0_IDX}) begin
        reg_select = 4'h0;
      end else if (idx == {2'h0, `BLK_B13_CTRL0_IDX}) begin
        reg_select = 4'h1;
      end else if (idx == {2'h0, `BLK_B20_CTRL0_IDX}) begin
        reg_select = 4'h2;
      end else if (idx == {2'h0, `BLK_B22_CTRL0_IDX}) begin
        reg_select = 4'h3;
      end else if (idx == {2'h0, `BLK_B11_CTRL1_IDX}) begin
        reg_select = 4'h4;
      end else if (idx == {2'h0, `BLK_B13_CTRL1_IDX}) begin
        reg_select = 4'h5;
      end else if (idx == {2'h0, `BLK_B20_CTRL1_IDX}) begin
        reg_select = 4'h6;
      end else if (idx == {2'h0, `BLK_B22_CTRL1_IDX}) begin
        reg_select = 4'h7;
      end else if (idx == {2'h0, `BLK_AUX_CTRL_IDX}) begin
        reg_select = SEL_AUX;
      end else if (idx == {2'h0, `BLK_STATUS_IDX}) begin
        reg_select = SEL_STAT;
      end else begin
        reg_select = SEL_NONE;
      end
    end
  endfunction

  // Register storage.
  reg  [7:0]            ctrl0_ff [0:3];
  reg  [7:0]            ctrl1_ff [0:3];
  reg  [`AUX_WIDTH-1:0] aux_ff;

  // Write channel holding registers.
  reg                   aw_hold_ff;
  reg  [11:0]           awaddr_ff;
  reg                   w_hold_ff;
  reg  [31:0]           wdata_ff;
  reg  [3:0]            wstrb_ff;
  reg                   bvalid_ff;
  reg  [1:0]            bresp_ff;

  // Read channel registers.
  reg                   rvalid_ff;
  reg  [31:0]           rdata_ff;
  reg  [1:0]            rresp_ff;
  reg  [31:0]           nxt_rdata;
  reg  [1:0]            nxt_rresp;

  // Previous samples of the external phases for edge detection.
  reg                   ext_one_d_ff;
  reg                   ext_two_d_ff;

  // Per-block phase logic state.
  reg  [NUM_BLK-1:0]    int_one_ff;
  reg  [NUM_BLK-1:0]    int_two_ff;
  reg  [NUM_BLK-1:0]    smp_in_ff;
  reg  [NUM_BLK-1:0]    smp_ref_ff;
  reg  [NUM_BLK-1:0]    out_conn_ff;
  reg  [NUM_BLK-1:0]    col_gate_ff;
  reg  [NUM_BLK-1:0]    col_oe_ff;
  reg  [NUM_BLK-1:0]    cmp_capt_ff;
  reg  [NUM_BLK-1:0]    cmp_held_ff;
  reg  [NUM_BLK-1:0]    cmp_bus_ff;

  wire                  wr_commit;
  wire [3:0]            wr_sel;
  wire [3:0]            rd_sel;
  integer               i;

  // Address and data may arrive in either order; each is parked until both are in.
  assign o_awready = ~aw_hold_ff & ~bvalid_ff;
  assign o_wready  = ~w_hold_ff & ~bvalid_ff;
  assign o_bvalid  = bvalid_ff;
  assign o_bresp   = bresp_ff;
  assign o_arready = ~rvalid_ff;
  assign o_rvalid  = rvalid_ff;
  assign o_rdata   = rdata_ff;
  assign o_rresp   = rresp_ff;
  assign wr_commit = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_sel    = reg_select(awaddr_ff);
  assign rd_sel    = reg_select(i_araddr);

  // Write channel capture and response.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= 12'h000;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= i_wdata;
        wstrb_ff  <= i_wstrb;
      end
      if (wr_commit) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_ff && i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Register file; byte lane zero carries every 8-bit register.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctrl0_ff[i] <= `CTRL_RESET;
        ctrl1_ff[i] <= `CTRL_RESET;
      end
      aux_ff <= `AUX_RESET;
    end else if (wr_commit) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_sel == i[3:0] && wstrb_ff[0]) begin
          ctrl0_ff[i] <= wdata_ff[7:0];
        end
        if (wr_sel == (i[3:0] + 4'h4) && wstrb_ff[0]) begin
          ctrl1_ff[i] <= wdata_ff[7:0];
        end
      end
      if (wr_sel == SEL_AUX) begin
        if (wstrb_ff[0]) begin
          aux_ff[7:0] <= wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
          aux_ff[`AUX_WIDTH-1:8] <= wdata_ff[`AUX_WIDTH-1:8];
        end
      end
    end
  end

  // Read data multiplexer; unused upper bits read as zero.
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `RESP_OKAY;
    if (rd_sel < 4'h4) begin
      nxt_rdata[7:0] = ctrl0_ff[rd_sel[1:0]];
    end else if (rd_sel < SEL_AUX) begin
      nxt_rdata[7:0] = ctrl1_ff[rd_sel[1:0]];
    end else if (rd_sel == SEL_AUX) begin
      nxt_rdata[`AUX_WIDTH-1:0] = aux_ff;
    end else if (rd_sel == SEL_STAT) begin
      nxt_rdata[15:0] = {out_conn_ff, cmp_bus_ff, int_two_ff, int_one_ff};
    end else begin
      nxt_rresp = `RESP_SLVERR;
    end
  end

  // Read channel: the answer is registered on the same edge that takes the address.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end else if (rvalid_ff && i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // The external phases are shared by all blocks, so one edge history serves them all.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ext_one_d_ff <= 1'b0;
      ext_two_d_ff <= 1'b0;
    end else begin
      ext_one_d_ff <= i_ext_phase_one;
      ext_two_d_ff <= i_ext_phase_two;
    end
  end

  // Per-block phase steering, bus gating and comparator latch.
  genvar g;
  generate
    for (g = 0; g < NUM_BLK; g = g + 1) begin : blk
      wire       swap      = ctrl0_ff[g][`CTRL0_SWAP_BIT];
      wire       aplate    = ctrl0_ff[g][`CTRL0_APLATE_BIT];
      wire       colbus_en = aux_ff[`AUX_COLBUS_LSB + g];
      wire       outbus_en = aux_ff[`AUX_OUTBUS_LSB + g];
      wire       cmpbus_en = aux_ff[`AUX_CMPBUS_LSB + g];
      wire       sample_hold_disable     = aux_ff[`AUX_SAMPLE_HOLD_DISABLE_BIT];
      wire [2:0] a_input_select      = ctrl1_ff[g][`CTRL1_A_INPUT_SELECT_MSB:`CTRL1_A_INPUT_SELECT_LSB];
      // Internal phases follow the external ones or the swapped pair.
      wire       int_one   = swap ? i_ext_phase_two : i_ext_phase_one;
      wire       int_two   = swap ? i_ext_phase_one : i_ext_phase_two;
      // Capture on falling internal phase two, present on rising internal phase one.
      wire       capt_ev   = swap ? (ext_one_d_ff & ~i_ext_phase_one)
                                  : (ext_two_d_ff & ~i_ext_phase_two);
      wire       out_ev    = swap ? (~ext_two_d_ff & i_ext_phase_two)
                                  : (~ext_one_d_ff & i_ext_phase_one);
      // The late-half marker belongs to the external phase two; with swap the whole phase is used anyway.
      wire       late_ok   = swap | sample_hold_disable | i_phase_two_late_half;

      // Static capacitor and mux settings are wired straight from the register bits.
      assign o_feedback_cap_units[6*g +: 6] = ctrl0_ff[g][`CTRL0_FEEDBACK_CAP_SIZE_BIT] ?
                                              `FEEDBACK_CAP_SIZE_UNITS_LARGE : `FEEDBACK_CAP_SIZE_UNITS_SMALL;
      assign o_a_path_cap_units[5*g +: 5] = ctrl0_ff[g][`CTRL0_A_PATH_CAP_UNITS_MSB:`CTRL0_A_PATH_CAP_UNITS_LSB];
      assign o_b_path_cap_units[5*g +: 5] = ctrl1_ff[g][`CTRL1_B_PATH_CAP_UNITS_MSB:`CTRL1_B_PATH_CAP_UNITS_LSB];
      assign o_a_input_select[3*g +: 3]   = a_input_select;
      assign o_a_input_reserved[g]        = (a_input_select == `A_INPUT_SELECT_RSVD_A) | (a_input_select == `A_INPUT_SELECT_RSVD_B);
      assign o_a_input_high_reference[g]  = (a_input_select == `A_INPUT_SELECT_HIGH_REF);

      // Phase-driven outputs are registered so the analog switches see clean levels.
      always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          int_one_ff[g]  <= 1'b0;
          int_two_ff[g]  <= 1'b0;
          smp_in_ff[g]   <= 1'b0;
          smp_ref_ff[g]  <= 1'b0;
          out_conn_ff[g] <= 1'b0;
          col_gate_ff[g] <= 1'b0;
          col_oe_ff[g]   <= 1'b0;
        end else begin
          int_one_ff[g]  <= int_one;
          int_two_ff[g]  <= int_two;
          smp_in_ff[g]   <= aplate ? int_two : int_one;
          smp_ref_ff[g]  <= aplate ? int_one : int_two;
          out_conn_ff[g] <= outbus_en & int_two & late_ok;
          col_oe_ff[g]   <= colbus_en;
          col_gate_ff[g] <= colbus_en & (swap | (int_two & i_phase_two_late_half));
        end
      end

      // Comparator latch: the held value changes only at an output event.
      always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          cmp_capt_ff[g] <= 1'b0;
          cmp_held_ff[g] <= 1'b0;
          cmp_bus_ff[g]  <= 1'b0;
        end else begin
          if (capt_ev) begin
            cmp_capt_ff[g] <= i_comp_out[g];
          end
          if (out_ev) begin
            cmp_held_ff[g] <= cmp_capt_ff[g];
          end
          // Each block owns its column, so an undriven bus is simply held low.
          cmp_bus_ff[g] <= cmpbus_en & cmp_held_ff[g];
        end
      end
    end
  endgenerate

  assign o_int_phase_one         = int_one_ff;
  assign o_int_phase_two         = int_two_ff;
  assign o_a_sample_input        = smp_in_ff;
  assign o_a_sample_reference    = smp_ref_ff;
  assign o_out_bus_connect       = out_conn_ff;
  assign o_column_bus_gate       = col_gate_ff;
  assign o_column_bus_oe         = col_oe_ff;
  assign o_comparator_column_bus = cmp_bus_ff;

endmodule

// ==== test/sc_switch_partner.sv ====
`timescale 1ns/10ps

module sc_switch_partner (
  input  wire       i_core_clk,
  output wire       o_ext_phase_one,
  output wire       o_ext_phase_two,
  output wire       o_late_half,
  output wire [3:0] o_comp_out
);
  reg [3:0] cnt_ff  = 4'h0;
  reg [3:0] comp_ff = 4'h0;

  // Phase one spans counts 1 to 6, phase two 9 to 14; two idle counts keep them from overlapping.
  assign o_ext_phase_one = (cnt_ff >= 4'h1) && (cnt_ff <= 4'h6);
  assign o_ext_phase_two = (cnt_ff >= 4'h9) && (cnt_ff <= 4'he);
  assign o_late_half     = (cnt_ff >= 4'hc) && (cnt_ff <= 4'he);
  assign o_comp_out      = comp_ff;

  // The comparators settle late in phase one, at count 5, away from either capture edge.
  always @(posedge i_core_clk) begin
    cnt_ff <= cnt_ff + 4'h1;
    if (cnt_ff == 4'h4)
      comp_ff <= comp_ff + 4'h5;
  end
endmodule

// ==== test/sc_type_b_regs_monitor.sv ====
`timescale 1ns/10ps
`include "sc_type_b_map.vh"

module sc_type_b_regs_monitor #(
  parameter NUM_BLK = 4
) (
  input wire                 i_core_clk,
  input wire                 i_sys_rst,
  input wire                 i_awvalid,
  input wire                 o_awready,
  input wire                 i_wvalid,
  input wire                 o_wready,
  input wire                 o_bvalid,
  input wire                 i_bready,
  input wire                 i_arvalid,
  input wire                 o_arready,
  input wire [31:0]          o_rdata,
  input wire                 o_rvalid,
  input wire                 i_rready,
  input wire                 i_ext_phase_one,
  input wire                 i_ext_phase_two,
  input wire [3*NUM_BLK-1:0] o_a_input_select,
  input wire [NUM_BLK-1:0]   o_a_input_reserved,
  input wire [NUM_BLK-1:0]   o_a_input_high_reference,
  input wire [NUM_BLK-1:0]   o_int_phase_one,
  input wire [NUM_BLK-1:0]   o_int_phase_two,
  input wire [NUM_BLK-1:0]   o_out_bus_connect,
  input wire [NUM_BLK-1:0]   o_comparator_column_bus
);
  // All checks live in the core clock domain.
  default clocking mon_clk @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // Internal phases are the external pair, straight or crossed, one cycle late.
  phase_map_a: assert property (!$past(i_sys_rst) |->
    ({o_int_phase_one[0], o_int_phase_two[0]} == $past({i_ext_phase_one, i_ext_phase_two})) ||
    ({o_int_phase_one[0], o_int_phase_two[0]} == $past({i_ext_phase_two, i_ext_phase_one})))
    else $error("internal phases do not track external phases");
  // Registered gating may trail the phase by one cycle, so the previous cycle also counts.
  out_bus_phase_a: assert property ($rose(o_out_bus_connect[0]) |->
    o_int_phase_two[0] || $past(o_int_phase_two[0])) else $error("output bus closed outside phase two");
  cmp_event_a: assert property ($changed(o_comparator_column_bus[0]) |->
    o_int_phase_one[0] || $past(o_int_phase_one[0])) else $error("comparator bus moved between events");
  a_input_select_flags_a: assert property ((o_a_input_high_reference[0] == (o_a_input_select[2:0] == `A_INPUT_SELECT_HIGH_REF)) &&
    (o_a_input_reserved[0] == (o_a_input_select[2:1] == 2'b11))) else $error("input select flags wrong");
  wr_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
endmodule

bind sc_type_b_control_regs sc_type_b_regs_monitor #(.NUM_BLK(NUM_BLK)) monitor_inst (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .i_ext_phase_one(i_ext_phase_one), .i_ext_phase_two(i_ext_phase_two),
  .o_a_input_select(o_a_input_select), .o_a_input_reserved(o_a_input_reserved),
  .o_a_input_high_reference(o_a_input_high_reference), .o_int_phase_one(o_int_phase_one),
  .o_int_phase_two(o_int_phase_two), .o_out_bus_connect(o_out_bus_connect),
  .o_comparator_column_bus(o_comparator_column_bus));

// ==== test/sc_type_b_control_regs_tb.sv ====
`timescale 1ns/10ps
`include "sc_type_b_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module sc_type_b_control_regs_tb;
  typedef struct packed { logic [7:0] c0; logic [12:0] aux; logic [3:0] k, o, g, e, s, r; } row_t;
  localparam logic [7:0] C0 [4] = '{`BLK_B11_CTRL0_IDX, `BLK_B13_CTRL0_IDX, `BLK_B20_CTRL0_IDX, `BLK_B22_CTRL0_IDX};
  // Control zero, aux, wait after phase one rises, then bus, gate, enable, input and reference samples.
  row_t rows [7] = '{{8'h00, 13'h00ff, 24'h300ff0}, {8'h00, 13'h00ff, 24'ha00f0f}, {8'ha5, 13'h00ff, 24'hdffff0},
    {8'h5f, 13'h00ff, 24'h3fff0f}, {8'h40, 13'h00ff, 24'ha0fff0}, {8'h00, 13'h1050, 24'ha5000f},
    {8'h80, 13'h1050, 24'hd5000f}};
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [3:0]  snap;
  wire         awr, wrd, bv, arr, rv, p1, p2, late;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [23:0] feedback_cap_size;
  wire  [19:0] a_path_cap_units, b_path_cap_units;
  wire  [11:0] asel;
  wire  [3:0]  arsv, ahi, si, sr, ob, cg, coe, cb, comp;
  int          num_errors = 0, check_count = 0, b, n;

  sc_type_b_control_regs sc_type_b_control_regs_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv),
    .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rry),
    .i_ext_phase_one(p1), .i_ext_phase_two(p2), .i_phase_two_late_half(late), .i_comp_out(comp),
    .o_feedback_cap_units(feedback_cap_size), .o_a_path_cap_units(a_path_cap_units), .o_b_path_cap_units(b_path_cap_units),
    .o_a_input_select(asel), .o_a_input_reserved(arsv), .o_a_input_high_reference(ahi),
    .o_int_phase_one(), .o_int_phase_two(), .o_a_sample_input(si), .o_a_sample_reference(sr),
    .o_out_bus_connect(ob), .o_column_bus_gate(cg), .o_column_bus_oe(coe), .o_comparator_column_bus(cb));
  sc_switch_partner sc_switch_partner_inst (.i_core_clk(clk), .o_ext_phase_one(p1), .o_ext_phase_two(p2),
    .o_late_half(late), .o_comp_out(comp));

  // A 20 ns core clock.
  initial begin
    forever #10 clk = ~clk;
  end

  function automatic [11:0] ba(input [7:0] i);
    ba = {2'b00, i, 2'b00};
  endfunction

  task automatic wrap_up(input int extra);
    num_errors += extra;
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Write with the response stalled st cycles; the done test comes first so bready is never driven twice.
  task automatic wr(input [11:0] a, input [31:0] d, input [1:0] e, input int st);
    int i;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= (st == 0);
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (bv && bry) break;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (i == st) bry <= 1'b1;
    end
    if (i == 60) wrap_up(1);
    `CHK(bresp, e)
  endtask

  task automatic rd(input [11:0] a, input [31:0] d, input [1:0] e, input int st);
    int i;
    ara <= a;
    arv <= 1'b1;
    rry <= (st == 0);
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (rv && rry) break;
      if (arr) arv <= 1'b0;
      if (i == st) rry <= 1'b1;
    end
    if (i == 60) wrap_up(1);
    `CHK(rdata, d)
    `CHK(rresp, e)
  endtask

  // Finds the edge that first sees phase one high, then waits k more edges.
  task automatic sync(input int k);
    int i;
    logic prev;
    prev = 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (p1 && !prev) break;
      prev = p1;
    end
    if (i == 40) wrap_up(1);
    repeat (k) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(feedback_cap_size, {4{6'h10}})
    for (n = 0; n < 8; n++)
      rd(ba(C0[n % 4] + 8'(n / 4)), 32'h0, `RESP_OKAY, 0);
    foreach (rows[i]) begin
      for (b = 0; b < 4; b++)
        wr(ba(C0[b]), {24'h0, rows[i].c0}, `RESP_OKAY, b);
      wr(ba(`BLK_AUX_CTRL_IDX), {19'h0, rows[i].aux}, `RESP_OKAY, 0);
      rd(ba(C0[i % 4]), {24'h0, rows[i].c0}, `RESP_OKAY, i % 3);
      sync(rows[i].k);
      `CHK(ob, rows[i].o)
      `CHK(cg, rows[i].g)
      `CHK(coe, rows[i].e)
      `CHK(si, rows[i].s)
      `CHK(sr, rows[i].r)
      `CHK(feedback_cap_size, {4{rows[i].c0[7] ? 6'h20 : 6'h10}})
      `CHK(a_path_cap_units, {4{rows[i].c0[4:0]}})
    end
    // Every input select code, spread over the blocks, with a falling B count beside it.
    for (n = 0; n < 8; n++) begin
      b = n % 4;
      wr(ba(C0[b] + 8'h01), {24'h0, n[2:0], 5'h1f - 5'(n)}, `RESP_OKAY, 0);
      `CHK(asel[3*b +: 3], n[2:0])
      `CHK(ahi[b], n[2:0] == `A_INPUT_SELECT_HIGH_REF)
      `CHK(arsv[b], n[2:1] == 2'b11)
      `CHK(b_path_cap_units[5*b +: 5], 5'h1f - 5'(n))
      rd(ba(C0[b] + 8'h01), {24'h0, n[2:0], 5'h1f - 5'(n)}, `RESP_OKAY, 1);
    end
    rd(ba(`BLK_AUX_CTRL_IDX), 32'h0000_1050, `RESP_OKAY, 1);
    wr(12'hffc, 32'h0000_00ff, `RESP_SLVERR, 2);
    rd(12'hffc, 32'h0, `RESP_SLVERR, 2);
    wr(ba(C0[0]) + 12'h001, 32'h0000_00ff, `RESP_SLVERR, 0);
    rd(ba(C0[0]), 32'h0000_0080, `RESP_OKAY, 0);
    // Comparator bus is switched only while internal phase one is high, so it never moves off an event.
    for (b = 0; b < 2; b++) begin
      for (n = 0; n < 4; n++)
        wr(ba(C0[n]), {24'h0, 1'b0, b[0], 6'h00}, `RESP_OKAY, 0);
      sync(b ? 8 : 0);
      wr(ba(`BLK_AUX_CTRL_IDX), 32'h0000_0f00, `RESP_OKAY, 0);
      repeat (2) begin
        sync(b ? 13 : 0);
        snap = comp;
        if (b == 0) repeat (4) @(posedge clk);
        `CHK(cb, snap)
      end
      sync(b ? 8 : 0);
      wr(ba(`BLK_AUX_CTRL_IDX), 32'h0, `RESP_OKAY, 0);
      repeat (3) @(posedge clk);
      `CHK(cb, 4'h0)
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ba(C0[3]), 32'h0, `RESP_OKAY, 0);
    `CHK(feedback_cap_size, {4{6'h10}})
    wrap_up(0);
  end
endmodule
